/* dpc_pkg.sv */
// Package with register map, field layout, limits and types of the dual PLL path configuration.
// How it works
// - Output-source, first-bypass and feedback selects pick one of four modes.
// - First feedback divider is 12 bits; extended feedback divider is 9 bits, 4..511.
// - Feedback select 0 uses own divider; 1 routes through second PLL, both dividers.
// - Second PLL prescaler is 6 bits, range 1 to 63.
// - Second PLL feedback divider is 9 bits, range 8 to 511.
// - Five channel dividers divide 1 to 200 from VCO or oscillator clock.
// - SYSREF divider is twice a product of coded factors, 64 to 12800.
// - Second PLL VCO runs fixed at 3686.4 MHz for all dividers.
// - Doubler enabled makes the second prescale ratio count as one half.
// - One lock output reflects lock state of each PLL that the mode uses.
// - Channels and unused blocks can be powered down by software.
// - First bypass disables first PLL and feeds second from prescaled input.
// - Output-source one feeds channels from first PLL, bypassing the second.
// - Doubler enabled makes the second prescaler ineffective.
package dpc_pkg;
   // Register word indexes; byte address is four times the index.
   localparam logic [5:0] IDX_CTRL    = 6'h00;
   localparam logic [5:0] IDX_PV      = 6'h01;
   localparam logic [5:0] IDX_MV0     = 6'h02;
   localparam logic [5:0] IDX_MV1     = 6'h03;
   localparam logic [5:0] IDX_PF      = 6'h04;
   localparam logic [5:0] IDX_MF      = 6'h05;
   localparam logic [5:0] IDX_NA      = 6'h06;
   localparam logic [5:0] IDX_NE      = 6'h0A;
   localparam logic [5:0] IDX_SRCODE  = 6'h0B;
   localparam logic [5:0] IDX_PDOWN   = 6'h0C;
   localparam logic [5:0] IDX_STATUS  = 6'h0D;
   localparam logic [5:0] IDX_IRQ_ST  = 6'h0E;
   localparam logic [5:0] IDX_IRQ_CLR = 6'h0F;
   localparam logic [5:0] IDX_IRQ_EN  = 6'h10;
   localparam logic [5:0] IDX_SR_DIV  = 6'h11;
   localparam logic [5:0] IDX_VCO_KHZ = 6'h12;
   // Control register bits.
   localparam int CTRL_SRC  = 0;
   localparam int CTRL_FIRST_PLL_BYPASS = 1;
   localparam int CTRL_FEEDBACK_PATH_SEL = 2;
   localparam int CTRL_FDF  = 3;
   // Power-down register bits; bits 4:0 are channels A to E.
   localparam int PD_PLL1   = 5;
   localparam int PD_PLL2   = 6;
   localparam int PD_SYSREF = 7;
   // Interrupt event bits.
   localparam int IRQ_LOCK_GAIN = 0;
   localparam int IRQ_LOCK_LOSS = 1;
   localparam int IRQ_CLAMP     = 2;
   localparam int NUM_IRQ       = 3;
   // Divider limits.
   localparam int PV_MIN  = 1;
   localparam int PV_MAX  = 4095;
   localparam int MV0_MIN = 1;
   localparam int MV0_MAX = 4095;
   localparam int MV1_MIN = 4;
   localparam int MV1_MAX = 511;
   localparam int PF_MIN  = 1;
   localparam int PF_MAX  = 63;
   localparam int MF_MIN  = 8;
   localparam int MF_MAX  = 511;
   localparam int N_MIN   = 1;
   localparam int N_MAX   = 200;
   localparam int NUM_CH  = 5;
   // Fixed VCO frequency in kHz.
   localparam logic [31:0] VCO_FREQ_KHZ = 32'h0038_4000;
   // Reset values.
   localparam logic [3:0]  CTRL_RST   = 4'h0;
   localparam logic [11:0] PV_RST     = 12'h001;
   localparam logic [11:0] MV0_RST    = 12'h001;
   localparam logic [8:0]  MV1_RST    = 9'h004;
   localparam logic [5:0]  PF_RST     = 6'h01;
   localparam logic [8:0]  MF_RST     = 9'h008;
   localparam logic [7:0]  N_RST      = 8'h01;
   localparam logic [7:0]  SRCODE_RST = 8'h00;
   localparam logic [7:0]  PDOWN_RST  = 8'h00;

   typedef enum logic [1:0] {
      MODE_DUAL_DET,
      MODE_DUAL,
      MODE_PLL1_BYP,
      MODE_PLL2_BYP
   } dpc_mode_t;
endpackage : dpc_pkg

/* dpc_sysref_div.sv */
// Decoder from packed SYSREF factor codes to the SYSREF divide value.
`timescale 1ns/100ps
module dpc_sysref_div (
   // Factor codes: [1:0] {2,4,8,16}, [3:2] {2,3,4,5}, [4] {2,4}, [5] {2,4}, [7:6] {2,3,4,5}
   input  wire logic [7:0]  code_i,
   // Divide value, 64 to 12800
   output logic      [13:0] div_o
);
   function automatic logic [4:0] pow2_fac(input logic [1:0] c);
      pow2_fac = 5'h02 << c;
   endfunction : pow2_fac

   function automatic logic [4:0] lin_fac(input logic [1:0] c);
      lin_fac = 5'h02 + {3'h0, c};
   endfunction : lin_fac

   logic [27:0] prod;

   always_comb begin
      prod = 28'h0000002 * {23'h0, pow2_fac(code_i[1:0])} * {23'h0, lin_fac(code_i[3:2])}
             * {23'h0, pow2_fac({1'b0, code_i[4]})} * {23'h0, pow2_fac({1'b0, code_i[5]})}
             * {23'h0, lin_fac(code_i[7:6])};
      div_o = prod[13:0];
   end
endmodule : dpc_sysref_div

/* dpc_lock_comb.sv */
// Combiner of the two PLL lock flags by operating mode.
`timescale 1ns/100ps
module dpc_lock_comb (
   // Mode selects
   input  wire logic src_i,
   input  wire logic first_pll_bypass_i,
   // Power-down of each PLL
   input  wire logic pd_pll1_i,
   input  wire logic pd_pll2_i,
   // Lock flags from the PLLs
   input  wire logic pll1_lock_i,
   input  wire logic pll2_lock_i,
   // Combined lock
   output logic      lock_o
);
   logic pll1_act;
   logic pll2_act;

   always_comb begin
      pll1_act = !first_pll_bypass_i;
      pll2_act = !src_i;
      lock_o = (pll1_act || pll2_act)
               && (!pll1_act || (pll1_lock_i && !pd_pll1_i))
               && (!pll2_act || (pll2_lock_i && !pd_pll2_i));
   end
endmodule : dpc_lock_comb

/* dpc_top.sv */
// Dual PLL path configuration registers, mode decode, lock and interrupt logic.
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module dpc_top (
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // PLL lock flags
   input  wire logic        pll1_lock_i,
   input  wire logic        pll2_lock_i,
   // Mode selects
   output logic             output_source_sel_o,
   output logic             first_pll_bypass_o,
   output logic             feedback_path_sel_o,
   output logic             freq_doubler_en_o,
   output logic      [1:0]  mode_o,
   output logic             fb_through_pll2_o,
   output logic             pll1_enable_o,
   output logic             pll2_enable_o,
   output logic             manual_input_only_o,
   // Divider settings
   output logic      [11:0] first_pll_prediv_o,
   output logic      [11:0] first_pll_feedback_div_o,
   output logic      [8:0]  extended_loop_feedback_div_o,
   output logic      [5:0]  second_pll_prediv_o,
   output logic      [6:0]  second_pll_ratio_x2_o,
   output logic      [8:0]  second_pll_feedback_div_o,
   output logic      [39:0] channel_divider_o,
   output logic      [13:0] sysref_div_o,
   // Power and lock
   output logic      [4:0]  channel_enable_o,
   output logic             sysref_enable_o,
   output logic             lock_o,
   output logic             irq_o
);
   typedef struct packed {
      logic                 src;
      logic                 first_pll_bypass;
      logic                 feedback_path_sel;
      logic                 fdf;
      logic [11:0]          pv;
      logic [11:0]          mv0;
      logic [8:0]           mv1;
      logic [5:0]           pf;
      logic [8:0]           mf;
      logic [39:0]          nch;
      logic [7:0]           srcode;
      logic [7:0]           pdown;
      logic [2:0]           irq_st;
      logic [2:0]           irq_en;
      logic [1:0]           mode;
      logic                 fb_both;
      logic                 pll1_on;
      logic                 pll2_on;
      logic [5:0]           pf_eff;
      logic                 manual;
      logic [6:0]           ratio_x2;
      logic [13:0]          sr_div;
      logic [4:0]           ch_en;
      logic                 sr_en;
      logic                 lock;
      logic                 irq;
      logic                 ack;
      logic [31:0]          rdat;
   } dpc_state_t;

   dpc_state_t st_r;
   dpc_state_t st_nxt;
   logic [13:0] sr_div_w;
   logic        lock_w;
   logic        req;
   logic        wr;
   logic [5:0]  idx;
   logic [2:0]  ev;
   logic        clamp_ev;
   logic [31:0] wval;
   logic [2:0]  ch;

   // Merges the write data into the current word by byte enables.
   function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] d,
                                         input logic [3:0] sel);
      logic [31:0] m;
      m = cur;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            m[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return m;
   endfunction : merge

   // Limits a written value to its legal range.
   function automatic logic [15:0] clamp(input logic [31:0] v, input int lo, input int hi);
      if (v < 32'(lo)) begin
         return 16'(lo);
      end else if (v > 32'(hi)) begin
         return 16'(hi);
      end else begin
         return v[15:0];
      end
   endfunction : clamp

   // Reports whether a written value lies outside its range.
   function automatic logic out_of(input logic [31:0] v, input int lo, input int hi);
      return (v < 32'(lo)) || (v > 32'(hi));
   endfunction : out_of

   dpc_sysref_div u_sysref (
      .code_i (st_r.srcode),
      .div_o  (sr_div_w)
   );

   dpc_lock_comb u_lock (
      .src_i       (st_r.src),
      .first_pll_bypass_i      (st_r.first_pll_bypass),
      .pd_pll1_i   (st_r.pdown[dpc_pkg::PD_PLL1]),
      .pd_pll2_i   (st_r.pdown[dpc_pkg::PD_PLL2]),
      .pll1_lock_i (pll1_lock_i),
      .pll2_lock_i (pll2_lock_i),
      .lock_o      (lock_w)
   );

   always_comb begin
      st_nxt   = st_r;
      req      = wb_cyc_i && wb_stb_i && !st_r.ack;
      wr       = req && wb_we_i;
      idx      = wb_adr_i[7:2];
      clamp_ev = 1'b0;
      ch       = 3'h0;
      wval     = 32'h0000_0000;
      st_nxt.ack = req;
      // Register writes with range limiting.
      if (wr) begin
         case (idx)
            dpc_pkg::IDX_CTRL: begin
               wval = merge({28'h0, st_r.fdf, st_r.feedback_path_sel, st_r.first_pll_bypass, st_r.src},
                            wb_dat_i, wb_sel_i);
               st_nxt.src  = wval[dpc_pkg::CTRL_SRC];
               st_nxt.first_pll_bypass = wval[dpc_pkg::CTRL_FIRST_PLL_BYPASS];
               st_nxt.feedback_path_sel = wval[dpc_pkg::CTRL_FEEDBACK_PATH_SEL];
               st_nxt.fdf  = wval[dpc_pkg::CTRL_FDF];
            end
            dpc_pkg::IDX_PV: begin
               wval     = merge({20'h0, st_r.pv}, wb_dat_i, wb_sel_i);
               st_nxt.pv = 12'(clamp(wval, dpc_pkg::PV_MIN, dpc_pkg::PV_MAX));
               clamp_ev = out_of(wval, dpc_pkg::PV_MIN, dpc_pkg::PV_MAX);
            end
            dpc_pkg::IDX_MV0: begin
               wval      = merge({20'h0, st_r.mv0}, wb_dat_i, wb_sel_i);
               st_nxt.mv0 = 12'(clamp(wval, dpc_pkg::MV0_MIN, dpc_pkg::MV0_MAX));
               clamp_ev  = out_of(wval, dpc_pkg::MV0_MIN, dpc_pkg::MV0_MAX);
            end
            dpc_pkg::IDX_MV1: begin
               wval      = merge({23'h0, st_r.mv1}, wb_dat_i, wb_sel_i);
               st_nxt.mv1 = 9'(clamp(wval, dpc_pkg::MV1_MIN, dpc_pkg::MV1_MAX));
               clamp_ev  = out_of(wval, dpc_pkg::MV1_MIN, dpc_pkg::MV1_MAX);
            end
            dpc_pkg::IDX_PF: begin
               wval     = merge({26'h0, st_r.pf}, wb_dat_i, wb_sel_i);
               st_nxt.pf = 6'(clamp(wval, dpc_pkg::PF_MIN, dpc_pkg::PF_MAX));
               clamp_ev = out_of(wval, dpc_pkg::PF_MIN, dpc_pkg::PF_MAX);
            end
            dpc_pkg::IDX_MF: begin
               wval     = merge({23'h0, st_r.mf}, wb_dat_i, wb_sel_i);
               st_nxt.mf = 9'(clamp(wval, dpc_pkg::MF_MIN, dpc_pkg::MF_MAX));
               clamp_ev = out_of(wval, dpc_pkg::MF_MIN, dpc_pkg::MF_MAX);
            end
            dpc_pkg::IDX_SRCODE: begin
               wval         = merge({24'h0, st_r.srcode}, wb_dat_i, wb_sel_i);
               st_nxt.srcode = wval[7:0];
            end
            dpc_pkg::IDX_PDOWN: begin
               wval        = merge({24'h0, st_r.pdown}, wb_dat_i, wb_sel_i);
               st_nxt.pdown = wval[7:0];
            end
            dpc_pkg::IDX_IRQ_EN: begin
               wval         = merge({29'h0, st_r.irq_en}, wb_dat_i, wb_sel_i);
               st_nxt.irq_en = wval[2:0];
            end
            default: begin
               if (idx >= dpc_pkg::IDX_NA && idx <= dpc_pkg::IDX_NE) begin
                  ch   = 3'(idx - dpc_pkg::IDX_NA);
                  wval = merge({24'h0, st_r.nch[ch*8 +: 8]}, wb_dat_i, wb_sel_i);
                  st_nxt.nch[ch*8 +: 8] = 8'(clamp(wval, dpc_pkg::N_MIN, dpc_pkg::N_MAX));
                  clamp_ev = out_of(wval, dpc_pkg::N_MIN, dpc_pkg::N_MAX);
               end
            end
         endcase
      end
      // Register reads; unmapped and write-only words read zero.
      st_nxt.rdat = 32'h0000_0000;
      if (req && !wb_we_i) begin
         case (idx)
            dpc_pkg::IDX_CTRL:    st_nxt.rdat = {28'h0, st_r.fdf, st_r.feedback_path_sel, st_r.first_pll_bypass, st_r.src};
            dpc_pkg::IDX_PV:      st_nxt.rdat = {20'h0, st_r.pv};
            dpc_pkg::IDX_MV0:     st_nxt.rdat = {20'h0, st_r.mv0};
            dpc_pkg::IDX_MV1:     st_nxt.rdat = {23'h0, st_r.mv1};
            dpc_pkg::IDX_PF:      st_nxt.rdat = {26'h0, st_r.pf};
            dpc_pkg::IDX_MF:      st_nxt.rdat = {23'h0, st_r.mf};
            dpc_pkg::IDX_SRCODE:  st_nxt.rdat = {24'h0, st_r.srcode};
            dpc_pkg::IDX_PDOWN:   st_nxt.rdat = {24'h0, st_r.pdown};
            dpc_pkg::IDX_STATUS:  st_nxt.rdat = {24'h0, st_r.mode, st_r.lock, st_r.pll2_on,
                                                 st_r.pll1_on, st_r.fb_both, pll2_lock_i,
                                                 pll1_lock_i};
            dpc_pkg::IDX_IRQ_ST:  st_nxt.rdat = {29'h0, st_r.irq_st};
            dpc_pkg::IDX_IRQ_EN:  st_nxt.rdat = {29'h0, st_r.irq_en};
            dpc_pkg::IDX_SR_DIV:  st_nxt.rdat = {18'h0, st_r.sr_div};
            dpc_pkg::IDX_VCO_KHZ: st_nxt.rdat = dpc_pkg::VCO_FREQ_KHZ;
            default: begin
               if (idx >= dpc_pkg::IDX_NA && idx <= dpc_pkg::IDX_NE) begin
                  ch = 3'(idx - dpc_pkg::IDX_NA);
                  st_nxt.rdat = {24'h0, st_r.nch[ch*8 +: 8]};
               end
            end
         endcase
      end
      if (st_r.src) begin
         st_nxt.mode = 2'(dpc_pkg::MODE_PLL2_BYP);
      end else if (st_r.first_pll_bypass) begin
         st_nxt.mode = 2'(dpc_pkg::MODE_PLL1_BYP);
      end else if (st_r.feedback_path_sel) begin
         st_nxt.mode = 2'(dpc_pkg::MODE_DUAL_DET);
      end else begin
         st_nxt.mode = 2'(dpc_pkg::MODE_DUAL);
      end
      st_nxt.fb_both = st_r.feedback_path_sel && !st_r.first_pll_bypass && !st_r.src;
      st_nxt.pll1_on = !st_r.first_pll_bypass && !st_r.pdown[dpc_pkg::PD_PLL1];
      st_nxt.manual  = st_r.first_pll_bypass || st_r.pdown[dpc_pkg::PD_PLL1];
      st_nxt.pll2_on = !st_r.src && !st_r.pdown[dpc_pkg::PD_PLL2];
      st_nxt.pf_eff = st_r.fdf ? 6'h00 : st_r.pf;
      st_nxt.ratio_x2 = st_r.fdf ? 7'h01 : {st_r.pf, 1'b0};
      st_nxt.sr_div = sr_div_w;
      st_nxt.ch_en = ~st_r.pdown[4:0];
      st_nxt.sr_en = !st_r.pdown[dpc_pkg::PD_SYSREF];
      st_nxt.lock = lock_w;
      // Sticky events; a new event wins over a clear in the same cycle.
      ev = 3'h0;
      ev[dpc_pkg::IRQ_LOCK_GAIN] = lock_w && !st_r.lock;
      ev[dpc_pkg::IRQ_LOCK_LOSS] = !lock_w && st_r.lock;
      ev[dpc_pkg::IRQ_CLAMP]     = clamp_ev;
      if (wr && idx == dpc_pkg::IDX_IRQ_CLR && wb_sel_i[0]) begin
         st_nxt.irq_st = st_r.irq_st & ~wb_dat_i[2:0];
      end
      st_nxt.irq_st = st_nxt.irq_st | ev;
      st_nxt.irq    = |(st_nxt.irq_st & st_nxt.irq_en);
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         st_r             <= '0;
         {st_r.fdf, st_r.feedback_path_sel, st_r.first_pll_bypass, st_r.src} <= dpc_pkg::CTRL_RST;
         st_r.pv          <= dpc_pkg::PV_RST;
         st_r.mv0         <= dpc_pkg::MV0_RST;
         st_r.mv1         <= dpc_pkg::MV1_RST;
         st_r.pf          <= dpc_pkg::PF_RST;
         st_r.pf_eff      <= dpc_pkg::PF_RST;
         st_r.mf          <= dpc_pkg::MF_RST;
         st_r.nch         <= {dpc_pkg::NUM_CH{dpc_pkg::N_RST}};
         st_r.srcode      <= dpc_pkg::SRCODE_RST;
         st_r.pdown       <= dpc_pkg::PDOWN_RST;
         st_r.mode        <= 2'(dpc_pkg::MODE_DUAL);
         st_r.pll1_on     <= 1'b1;
         st_r.pll2_on     <= 1'b1;
         st_r.ratio_x2    <= {dpc_pkg::PF_RST, 1'b0};
         st_r.ch_en       <= ~dpc_pkg::PDOWN_RST[4:0];
         st_r.sr_en       <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign wb_dat_o                     = st_r.rdat;
   assign wb_ack_o                     = st_r.ack;
   assign output_source_sel_o          = st_r.src;
   assign first_pll_bypass_o           = st_r.first_pll_bypass;
   assign feedback_path_sel_o          = st_r.feedback_path_sel;
   assign freq_doubler_en_o            = st_r.fdf;
   assign mode_o                       = st_r.mode;
   assign fb_through_pll2_o            = st_r.fb_both;
   assign pll1_enable_o                = st_r.pll1_on;
   assign pll2_enable_o                = st_r.pll2_on;
   assign manual_input_only_o          = st_r.manual;
   assign first_pll_prediv_o           = st_r.pv;
   assign first_pll_feedback_div_o     = st_r.mv0;
   assign extended_loop_feedback_div_o = st_r.mv1;
   assign second_pll_prediv_o          = st_r.pf_eff;
   assign second_pll_ratio_x2_o        = st_r.ratio_x2;
   assign second_pll_feedback_div_o    = st_r.mf;
   assign channel_divider_o            = st_r.nch;
   assign sysref_div_o                 = st_r.sr_div;
   assign channel_enable_o             = st_r.ch_en;
   assign sysref_enable_o              = st_r.sr_en;
   assign lock_o                       = st_r.lock;
   assign irq_o                        = st_r.irq;
endmodule : dpc_top

/* dpc_monitor.sv */
// Checker for the dual PLL path configuration block, bound to its top module.
`timescale 1ns/100ps
module dpc_monitor (
   // Clock, reset and bus handshake
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_ack_o,
   // Lock
   input  wire logic        pll1_lock_i,
   input  wire logic        pll2_lock_i,
   input  wire logic        lock_o,
   // Modes
   input  wire logic        output_source_sel_o,
   input  wire logic        first_pll_bypass_o,
   input  wire logic        feedback_path_sel_o,
   input  wire logic        freq_doubler_en_o,
   input  wire logic [1:0]  mode_o,
   input  wire logic        fb_through_pll2_o,
   input  wire logic        pll1_enable_o,
   input  wire logic        pll2_enable_o,
   // Dividers
   input  wire logic [5:0]  second_pll_prediv_o,
   input  wire logic [6:0]  second_pll_ratio_x2_o,
   input  wire logic [13:0] sysref_div_o
);
   logic [5:0] cfg;
   logic [5:0] c1_r;
   logic [5:0] c2_r;
   // Selects and enables; c1_r and c2_r tell whether they were steady.
   assign cfg = {output_source_sel_o, first_pll_bypass_o, feedback_path_sel_o,
                 freq_doubler_en_o, pll1_enable_o, pll2_enable_o};
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         c1_r <= 6'h03;
         c2_r <= 6'h03;
      end else begin
         c1_r <= cfg;
         c2_r <= c1_r;
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   AST_ACK_RESP:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   AST_ACK_ONE:
      assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   AST_MODE:
      assert property (cfg == c1_r |-> mode_o == (cfg[5] ? 2'h3 : (cfg[4] ? 2'h2 :
         (cfg[3] ? 2'h0 : 2'h1)))) else $error("bad mode");
   AST_FB:
      assert property (cfg == c1_r |-> fb_through_pll2_o == (cfg[3] && !cfg[4] && !cfg[5]))
      else $error("bad feedback path");
   AST_LOCK:
      assert property (!$past(rst_i) && cfg == c1_r && c1_r == c2_r |-> lock_o ==
         (!(cfg[5] && cfg[4]) && (cfg[4] || (cfg[1] && $past(pll1_lock_i)))
         && (cfg[5] || (cfg[0] && $past(pll2_lock_i))))) else $error("bad lock");
   AST_DBL:
      assert property (cfg == c1_r && cfg[2] |-> second_pll_ratio_x2_o == 7'h01
         && second_pll_prediv_o == 6'h00) else $error("bad doubler ratio");
   AST_DIV:
      assert property (!$past(rst_i) && cfg == c1_r && !cfg[2] && $stable(second_pll_prediv_o)
         |-> second_pll_ratio_x2_o == {second_pll_prediv_o, 1'b0}) else $error("bad ratio");
   AST_BYP:
      assert property (cfg == c1_r && cfg[4] |-> !pll1_enable_o) else $error("pll1 on");
   AST_SRC:
      assert property (cfg == c1_r && cfg[5] |-> !pll2_enable_o) else $error("pll2 on");
   AST_SRDIV:
      assert property (!$past(rst_i) |-> sysref_div_o >= 14'h0040 && sysref_div_o <= 14'h3200
         && !sysref_div_o[0]) else $error("bad sysref divider");
endmodule : dpc_monitor
bind dpc_top dpc_monitor u_mon (
   .clock_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .pll1_lock_i, .pll2_lock_i, .lock_o,
   .output_source_sel_o, .first_pll_bypass_o, .feedback_path_sel_o, .freq_doubler_en_o,
   .mode_o, .fb_through_pll2_o, .pll1_enable_o, .pll2_enable_o, .second_pll_prediv_o,
   .second_pll_ratio_x2_o, .sysref_div_o);

/* dpc_top_tb.sv */
// Self-checking testbench for the dual PLL path configuration block.
`timescale 1ns/100ps
module dpc_top_tb;
   logic        clock_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, l1 = 1'b0, l2 = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic        ack, fbp, man, sren, lock, irq;
   logic [1:0]  mode;
   logic [5:0]  pfd;
   logic [6:0]  ratio;
   logic [39:0] cha;
   logic [11:0] pvo, mvo0;
   logic [8:0]  mvo1, mfo;
   logic        pe1, pe2;
   wire  [3:0]  ctl;
   logic [13:0] srdiv;
   logic [4:0]  chen;
   int          err_count = 0;
   int          compares = 0;
   always #20 clock_i = ~clock_i;
   dpc_top dut (.clock_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .pll1_lock_i(l1), .pll2_lock_i(l2), .output_source_sel_o(ctl[0]),
      .first_pll_bypass_o(ctl[1]), .feedback_path_sel_o(ctl[2]), .freq_doubler_en_o(ctl[3]),
      .mode_o(mode), .fb_through_pll2_o(fbp), .pll1_enable_o(pe1), .pll2_enable_o(pe2),
      .manual_input_only_o(man), .first_pll_prediv_o(pvo), .first_pll_feedback_div_o(mvo0),
      .extended_loop_feedback_div_o(mvo1), .second_pll_prediv_o(pfd),
      .second_pll_ratio_x2_o(ratio), .second_pll_feedback_div_o(mfo), .channel_divider_o(cha),
      .sysref_div_o(srdiv), .channel_enable_o(chen), .sysref_enable_o(sren), .lock_o(lock),
      .irq_o(irq));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock_i);
      {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hF, d};
      do begin
         @(posedge clock_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      {cyc, stb, we} <= 3'h0;
      if (n >= 50) chk("ack", {31'h0, ack}, 32'h1);
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk($sformatf("reg_%h", a), q, exp);
   endtask : rd
   task automatic settle;
      repeat (2) @(posedge clock_i);
      @(negedge clock_i);
   endtask : settle
   task automatic drv(input logic a, input logic b);
      @(posedge clock_i);
      {l1, l2} <= {a, b};
      settle();
   endtask : drv
   task automatic t_reset;
      rd(8'h0C, 32'h4);
      rd(8'h10, 32'h1);
      rd(8'h14, 32'h8);
      rd(8'h28, 32'h1);
      rd(8'h48, 32'h0038_4000);
      rd(8'h80, 32'h0);
      chk("sysref", {18'h0, srdiv}, 32'h40);
      chk("pv", {20'h0, pvo}, 32'h1);
      chk("mv1", {23'h0, mvo1}, 32'h4);
      bus(1'b1, 8'h04, 32'h2);
      bus(1'b1, 8'h08, 32'h2);
      bus(1'b1, 8'h14, 32'h1E);
      chk("pv", {20'h0, pvo}, 32'h2);
      chk("mv0", {20'h0, mvo0}, 32'h2);
      chk("mf", {23'h0, mfo}, 32'h1E);
   endtask : t_reset
   task automatic t_modes;
      logic [3:0] c [5] = '{4'h4, 4'h0, 4'h2, 4'h1, 4'h3};
      logic [1:0] m [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, 8'h00, {28'h0, c[i]});
         settle();
         chk("mode", {30'h0, mode}, {30'h0, m[i]});
         chk("fb_path", {31'h0, fbp}, {31'h0, c[i] == 4'h4});
         chk("manual", {31'h0, man}, {31'h0, c[i][1]});
         chk("ctl", {28'h0, ctl}, {28'h0, c[i]});
         chk("pll1_en", {31'h0, pe1}, {31'h0, !c[i][1]});
         chk("pll2_en", {31'h0, pe2}, {31'h0, !c[i][0]});
      end
   endtask : t_modes
   task automatic t_dbl;
      bus(1'b1, 8'h10, 32'h5);
      bus(1'b1, 8'h00, 32'h8);
      settle();
      chk("ratio", {25'h0, ratio}, 32'h1);
      chk("prediv", {26'h0, pfd}, 32'h0);
      bus(1'b1, 8'h00, 32'h0);
      settle();
      chk("ratio", {25'h0, ratio}, 32'hA);
      bus(1'b1, 8'h2C, 32'h55);
      settle();
      chk("sysref", {18'h0, srdiv}, 32'h240);
      bus(1'b1, 8'h2C, 32'hFF);
      rd(8'h44, 32'h3200);
   endtask : t_dbl
   task automatic t_clamp;
      bus(1'b1, 8'h40, 32'h4);
      bus(1'b1, 8'h18, 32'hC9);
      rd(8'h18, 32'hC8);
      chk("cha", {24'h0, cha[7:0]}, 32'hC8);
      bus(1'b1, 8'h0C, 32'h3);
      rd(8'h0C, 32'h4);
      bus(1'b1, 8'h14, 32'h5);
      rd(8'h14, 32'h8);
      bus(1'b1, 8'h08, 32'h1000);
      chk("mv0", {20'h0, mvo0}, 32'hFFF);
      settle();
      chk("irq", {31'h0, irq}, 32'h1);
      rd(8'h38, 32'h4);
      bus(1'b1, 8'h3C, 32'h4);
      bus(1'b1, 8'h40, 32'h0);
      bus(1'b1, 8'h10, 32'h0);
      rd(8'h10, 32'h1);
      settle();
      chk("irq", {31'h0, irq}, 32'h0);
      rd(8'h38, 32'h4);
      bus(1'b1, 8'h3C, 32'h4);
   endtask : t_clamp
   task automatic t_lock;
      bus(1'b1, 8'h40, 32'h1);
      drv(1'b1, 1'b0);
      chk("lock", {31'h0, lock}, 32'h0);
      drv(1'b1, 1'b1);
      chk("lock", {31'h0, lock}, 32'h1);
      chk("irq", {31'h0, irq}, 32'h1);
      bus(1'b1, 8'h30, 32'h40);
      settle();
      chk("lock", {31'h0, lock}, 32'h0);
      bus(1'b1, 8'h30, 32'h85);
      settle();
      chk("lock", {31'h0, lock}, 32'h1);
      chk("chen", {27'h0, chen}, 32'h1A);
      chk("sren", {31'h0, sren}, 32'h0);
      bus(1'b1, 8'h00, 32'h2);
      drv(1'b0, 1'b1);
      chk("lock", {31'h0, lock}, 32'h1);
      bus(1'b1, 8'h00, 32'h1);
      settle();
      chk("lock", {31'h0, lock}, 32'h0);
      drv(1'b1, 1'b0);
      chk("lock", {31'h0, lock}, 32'h1);
      rd(8'h34, 32'hE9);
      rd(8'h38, 32'h3);
      bus(1'b1, 8'h3C, 32'h7);
      settle();
      chk("irq", {31'h0, irq}, 32'h0);
   endtask : t_lock
   task automatic end_sim;
      if (err_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   initial begin
      repeat (16) @(posedge clock_i);
      rst_i <= 1'b0;
      t_reset();
      t_modes();
      t_dbl();
      t_clamp();
      t_lock();
      end_sim();
   end
   initial begin
      repeat (3000) @(posedge clock_i);
      err_count++;
      end_sim();
   end
endmodule : dpc_top_tb
